// File: ffsup_conv_model.sv
// Converter model: drain valleys after demagnetisation, winding short sense.
// Assumes the gate drive is registered on the same 20 MHz clock.
`default_nettype none
module ffsup_conv_model #(
  parameter int DEMAG = 30,
  parameter int RING = 10
) (
  input wire logic clk_sys_in,
  input wire logic gate_in,
  input wire logic short_en_in,
  output logic valley_out,
  output logic short_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int off_cnt = 0;
  always @(posedge clk_sys_in) begin
    off_cnt <= gate_in ? 0 : off_cnt + 1;
  end
  // The drain keeps ringing while the switch rests, so valleys recur.
  assign valley_out = !gate_in && off_cnt >= DEMAG &&
    (off_cnt - DEMAG) % RING < 2;
  // A shorted winding lifts the sense level only while the switch conducts.
  assign short_out = short_en_in && gate_in;
endmodule // ffsup_conv_model
`default_nettype wire

// File: ffsup_count.sv
// Saturating consecutive-event counter with clear and done flag.
// Assumes step and clear are synchronous one-cycle qualifiers.
`default_nettype none
module ffsup_count #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] LIMIT = 3'h4
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic clear_in,
  input wire logic step_in,
  output logic done_out
);
  logic [WIDTH-1:0] cnt_reg;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || clear_in) begin
      cnt_reg <= '0;
    end else if (step_in && cnt_reg != LIMIT) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  assign done_out = (cnt_reg == LIMIT);
endmodule // ffsup_count
`default_nettype wire

// File: ffsup_pkg.sv
// Package for the flyback fault supervisor: variants, states and timing.
// Assumes a 20 MHz controller clock.
`default_nettype none
package ffsup_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int CLK_KHZ = CLK_HZ / 1000;
  localparam int SOFTSTART_MS = 4;
  localparam int SOFTSTART_CYC = SOFTSTART_MS * CLK_KHZ;
  localparam int UV_BLANK_MS = 37;
  localparam int UV_BLANK_CYC = UV_BLANK_MS * CLK_KHZ;
  localparam int CONFIRM_US = 10;
  localparam int CONFIRM_CYC = CONFIRM_US * (CLK_HZ / 1000000);
  localparam int CLAMP_LO_KHZ = 80;
  localparam int CLAMP_HI_KHZ = 110;
  // Least switching period rounds up so the frequency never exceeds clamp.
  localparam int CLAMP_LO_CYC = (CLK_KHZ + CLAMP_LO_KHZ - 1) / CLAMP_LO_KHZ;
  localparam int CLAMP_HI_CYC = (CLK_KHZ + CLAMP_HI_KHZ - 1) / CLAMP_HI_KHZ;
  localparam int OC_DELAY_CYC = 2000000;
  localparam int HICCUP_CYC = 200000;
  localparam logic [2:0] PULSE_COUNT = 3'h4;
  localparam logic [2:0] MAX_LOCK_VALLEY = 3'h4;
  localparam int PEAK_W = 8;
  typedef enum logic [1:0] {
    FFSUP_VAR_A = 2'h0,
    FFSUP_VAR_B = 2'h1,
    FFSUP_VAR_C = 2'h2
  } ffsup_variant_t;
  typedef enum logic [1:0] {
    FFSUP_CLAMP_NONE = 2'h0,
    FFSUP_CLAMP_80 = 2'h1,
    FFSUP_CLAMP_110 = 2'h2
  } ffsup_clamp_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SOFT = 5'h02,
    ST_RUN = 5'h04,
    ST_HICCUP = 5'h08,
    ST_LATCH = 5'h10
  } ffsup_state_t;
endpackage : ffsup_pkg
`default_nettype wire

// File: ffsup_sync.sv
// Two-flop synchroniser bank for asynchronous comparator flags.
// Assumes inputs come from analog comparators outside the clock domain.
`default_nettype none
module ffsup_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule // ffsup_sync
`default_nettype wire

// File: ffsup_top.sv
// Fault supervisor and drive gating for a quasi-resonant flyback controller.
// Assumes comparator flags are asynchronous and srst_in is supply power-up.
`default_nettype none
module ffsup_top
  import ffsup_pkg::*;
#(
  parameter int OC_DELAY = OC_DELAY_CYC,
  parameter int HICCUP = HICCUP_CYC,
  parameter int SOFTSTART = SOFTSTART_CYC,
  parameter int UV_BLANK = UV_BLANK_CYC
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire ffsup_variant_t variant_in,
  input wire ffsup_clamp_t clamp_in,
  input wire logic turn_on_req_in,
  input wire logic valley_in,
  input wire logic [2:0] valley_target_in,
  input wire logic line_change_in,
  input wire logic overcurrent_in,
  input wire logic winding_short_level_in,
  input wire logic supply_overvoltage_level_in,
  input wire logic out_overvoltage_in,
  input wire logic undervoltage_in,
  input wire logic cc_mode_in,
  input wire logic zero_cross_sense_fault_in,
  input wire logic overtemp_level_in,
  input wire logic supply_reset_in,
  output logic gate_drive_out,
  output logic [PEAK_W-1:0] peak_limit_out,
  output logic supply_clamp_out,
  output logic [2:0] locked_valley_out,
  output logic valley_locked_out,
  output logic overcurrent_fault_out,
  output logic undervoltage_fault_out,
  output logic latched_out,
  output logic hiccup_out
);
  localparam logic [PEAK_W-1:0] PEAK_MAX = '1;
  localparam int PEAK_STEP = SOFTSTART / (1 << PEAK_W);

  logic [7:0] flag_s;
  logic oc_s, short_s, vccov_s, outov_s, uv_s, cc_s, zcd_s, hot_s;
  ffsup_state_t state_reg;
  logic [31:0] tmr_reg, oc_tmr_reg, blank_reg, period_reg, step_reg;
  logic [31:0] vcc_conf_reg, hot_conf_reg;
  logic [1:0] hiccup_cnt_reg;
  logic drive_reg, drive_d_reg;
  logic off_edge, on_edge, uv_blank_done;
  logic short_done, outov_done, clean_done;
  logic vcc_fault, hot_fault, uv_fault, oc_fault;
  logic latch_req, hiccup_req;
  logic [31:0] min_period;

  ffsup_sync #(.WIDTH(8)) u_sync (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .async_in({overcurrent_in, winding_short_level_in,
      supply_overvoltage_level_in, out_overvoltage_in, undervoltage_in,
      cc_mode_in, zero_cross_sense_fault_in, overtemp_level_in}),
    .sync_out(flag_s)
  );
  assign {oc_s, short_s, vccov_s, outov_s, uv_s, cc_s, zcd_s, hot_s} = flag_s;

  assign on_edge = drive_reg && !drive_d_reg;
  assign off_edge = !drive_reg && drive_d_reg;

  // Consecutive-pulse counters sampled once per drive cycle at turn-off.
  ffsup_count #(.WIDTH(3), .LIMIT(PULSE_COUNT)) u_short (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .clear_in(off_edge && !short_s),
    .step_in(off_edge && short_s),
    .done_out(short_done)
  );
  ffsup_count #(.WIDTH(3), .LIMIT(PULSE_COUNT)) u_outov (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .clear_in((off_edge && !outov_s) || state_reg == ST_HICCUP),
    .step_in(off_edge && outov_s),
    .done_out(outov_done)
  );
  ffsup_count #(.WIDTH(3), .LIMIT(PULSE_COUNT)) u_clean (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .clear_in(off_edge && (oc_s || short_s)),
    .step_in(off_edge && !oc_s && !short_s),
    .done_out(clean_done)
  );

  // Overcurrent timer runs while the overload persists.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || state_reg != ST_RUN && state_reg != ST_SOFT) begin
      oc_tmr_reg <= '0;
    end else if (clean_done) begin
      oc_tmr_reg <= '0;
    end else if (oc_s && oc_tmr_reg != 32'(OC_DELAY)) begin
      oc_tmr_reg <= oc_tmr_reg + 32'h1;
    end
  end
  assign oc_fault = (oc_tmr_reg == 32'(OC_DELAY));

  // Ten microsecond confirmation for temperature and for the supply overvoltage latch of variants A and C.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !vccov_s) begin
      vcc_conf_reg <= '0;
    end else if (vcc_conf_reg != 32'(CONFIRM_CYC)) begin
      vcc_conf_reg <= vcc_conf_reg + 32'h1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !hot_s) begin
      hot_conf_reg <= '0;
    end else if (hot_conf_reg != 32'(CONFIRM_CYC)) begin
      hot_conf_reg <= hot_conf_reg + 32'h1;
    end
  end
  assign vcc_fault = (vcc_conf_reg == 32'(CONFIRM_CYC));
  assign hot_fault = (hot_conf_reg == 32'(CONFIRM_CYC));

  // Undervoltage blanking counted from the start of soft-start.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || state_reg == ST_IDLE) begin
      blank_reg <= '0;
    end else if (blank_reg != 32'(UV_BLANK)) begin
      blank_reg <= blank_reg + 32'h1;
    end
  end
  assign uv_blank_done = (blank_reg == 32'(UV_BLANK));
  assign uv_fault = uv_blank_done && uv_s && cc_s;

  // Variant decides latch versus auto-recovery for supply overvoltage, output overvoltage and undervoltage.
  always_comb begin
    latch_req = 1'b0;
    hiccup_req = 1'b0;
    if (state_reg == ST_RUN || state_reg == ST_SOFT) begin
      if (short_done) begin
        latch_req = 1'b1;
      end
      if (variant_in == FFSUP_VAR_B) begin
        hiccup_req = hiccup_req || vccov_s;
      end else if (vcc_fault) begin
        latch_req = 1'b1;
      end
      if (outov_done) begin
        if (variant_in == FFSUP_VAR_B) begin
          hiccup_req = 1'b1;
        end else begin
          latch_req = 1'b1;
        end
      end
      if (uv_fault) begin
        if (variant_in == FFSUP_VAR_C) begin
          latch_req = 1'b1;
        end else begin
          hiccup_req = 1'b1;
        end
      end
      if (oc_fault || hot_fault || (off_edge && zcd_s)) begin
        hiccup_req = 1'b1;
      end
    end
  end

  // Main fault state machine.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_reg <= ST_IDLE;
      tmr_reg <= '0;
      hiccup_cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          tmr_reg <= '0;
          state_reg <= ST_SOFT;
        end
        ST_SOFT, ST_RUN: begin
          if (latch_req) begin
            state_reg <= ST_LATCH;
          end else if (hiccup_req) begin
            state_reg <= ST_HICCUP;
            tmr_reg <= '0;
            hiccup_cnt_reg <= 2'h0;
          end else if (state_reg == ST_SOFT) begin
            tmr_reg <= tmr_reg + 32'h1;
            if (tmr_reg == 32'(SOFTSTART - 1)) begin
              state_reg <= ST_RUN;
            end
          end
        end
        ST_HICCUP: begin
          // Two hiccup periods; overtemperature holds until cooled.
          if (tmr_reg == 32'(HICCUP - 1)) begin
            tmr_reg <= '0;
            if (hiccup_cnt_reg == 2'h1 && !hot_s) begin
              state_reg <= ST_IDLE;
            end else if (hiccup_cnt_reg != 2'h1) begin
              hiccup_cnt_reg <= hiccup_cnt_reg + 2'h1;
            end
          end else begin
            tmr_reg <= tmr_reg + 32'h1;
          end
        end
        ST_LATCH: begin
          // Only the power-up reset releases the latch.
          state_reg <= ST_LATCH;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Soft-start peak ramp from zero to nominal.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || state_reg == ST_IDLE || state_reg == ST_HICCUP
        || state_reg == ST_LATCH) begin
      peak_limit_out <= '0;
      step_reg <= '0;
    end else if (state_reg == ST_RUN) begin
      peak_limit_out <= PEAK_MAX;
    end else if (step_reg == 32'(PEAK_STEP - 1)) begin
      step_reg <= '0;
      if (peak_limit_out != PEAK_MAX) begin
        peak_limit_out <= peak_limit_out + 1'b1;
      end
    end else begin
      step_reg <= step_reg + 32'h1;
    end
  end

  // Valley lock: hold a target of one to four until the line moves.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      locked_valley_out <= 3'h0;
      valley_locked_out <= 1'b0;
    end else if (valley_target_in > MAX_LOCK_VALLEY
                 || valley_target_in == 3'h0) begin
      valley_locked_out <= 1'b0;
      locked_valley_out <= 3'h0;
    end else if (!valley_locked_out || line_change_in) begin
      valley_locked_out <= 1'b1;
      locked_valley_out <= valley_target_in;
    end
  end

  always_comb begin
    case (clamp_in)
      FFSUP_CLAMP_80: min_period = 32'(CLAMP_LO_CYC);
      FFSUP_CLAMP_110: min_period = 32'(CLAMP_HI_CYC);
      default: min_period = 32'h0;
    endcase
  end

  // Drive: turn on in a valley, after the clamp period, during soft-start or run.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      drive_reg <= 1'b0;
      drive_d_reg <= 1'b0;
      period_reg <= '0;
    end else begin
      drive_d_reg <= drive_reg;
      if (on_edge) begin
        period_reg <= 32'h1;
      end else if (period_reg != 32'hFFFF_FFFF) begin
        period_reg <= period_reg + 32'h1;
      end
      if (latch_req || hiccup_req || oc_fault || vccov_s) begin
        drive_reg <= 1'b0;
      end else if (state_reg != ST_SOFT && state_reg != ST_RUN) begin
        drive_reg <= 1'b0;
      end else if (!drive_reg && turn_on_req_in && valley_in
                   && period_reg >= min_period) begin
        drive_reg <= 1'b1;
      end else if (drive_reg && !turn_on_req_in) begin
        drive_reg <= 1'b0;
      end
    end
  end

  assign gate_drive_out = drive_reg;
  assign supply_clamp_out = (state_reg == ST_LATCH);
  assign latched_out = (state_reg == ST_LATCH);
  assign hiccup_out = (state_reg == ST_HICCUP);
  assign overcurrent_fault_out = oc_fault;
  assign undervoltage_fault_out = uv_fault;

  AST_LATCH_HOLDS: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    latched_out |=> latched_out && !gate_drive_out)
    else $error("Latch released without reset.");
  AST_VCC_STOP: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    vccov_s |=> !gate_drive_out)
    else $error("Drive during supply overvoltage.");
  AST_OC_STOP: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    oc_fault |=> !gate_drive_out ##0 hiccup_out)
    else $error("Overcurrent did not stop drive.");
  AST_B_NO_LATCH: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    variant_in == FFSUP_VAR_B && !short_done |-> !latch_req)
    else $error("Variant B latched on a recoverable fault.");
  AST_SHORT_LATCH: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    short_done && state_reg == ST_RUN |=> latched_out)
    else $error("Winding short did not latch.");
  AST_UV_BLANK: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !uv_blank_done |-> !uv_fault)
    else $error("Undervoltage seen during blanking.");
  AST_VALLEY_RANGE: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    valley_locked_out |-> locked_valley_out <= MAX_LOCK_VALLEY)
    else $error("Locked valley above four.");
  AST_CLAMP_PERIOD: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    $rose(gate_drive_out) |-> $past(period_reg) >= min_period)
    else $error("Switching frequency above clamp.");
endmodule // ffsup_top
`default_nettype wire

// File: ffsup_top_bench.sv
// Self-checking bench for the fault supervisor with a converter model.
// Assumes shortened counts and a 20 MHz clock; notes are checked at falls.
`default_nettype none
module ffsup_top_bench;
  import ffsup_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OCD = 200;
  localparam int HIC = 100;
  localparam int SS = 512;
  localparam int UVB = 1000;
  localparam logic [7:0] LAT = 8'h06;
  localparam logic [7:0] HIQ = 8'h01;
  logic clk, srst, req, valley, line_chg, short_en, short_lvl, cc;
  logic gate, clamp_o, vlock, ocf, uvf, latched, hiccup;
  ffsup_variant_t variant;
  ffsup_clamp_t clamp;
  logic [2:0] vtgt, tgt, lvalley;
  logic [5:0] flt;
  logic [PEAK_W-1:0] peak;
  logic [7:0] meas;
  logic [10:0] q[$];
  logic [10:0] nt;
  int err_total, compares, on_len, t, lim;
  int on_cnt = 0;
  integer seed = 32'hE53C;

  ffsup_top #(.OC_DELAY(OCD), .HICCUP(HIC), .SOFTSTART(SS),
    .UV_BLANK(UVB)) uut (.clk_sys_in(clk), .srst_in(srst),
    .variant_in(variant), .clamp_in(clamp), .turn_on_req_in(req),
    .valley_in(valley), .valley_target_in(vtgt),
    .line_change_in(line_chg), .overcurrent_in(flt[0]),
    .winding_short_level_in(short_lvl),
    .supply_overvoltage_level_in(flt[1]), .out_overvoltage_in(flt[2]),
    .undervoltage_in(flt[3]), .cc_mode_in(cc),
    .zero_cross_sense_fault_in(flt[4]), .overtemp_level_in(flt[5]),
    .supply_reset_in(srst), .gate_drive_out(gate),
    .peak_limit_out(peak), .supply_clamp_out(clamp_o),
    .locked_valley_out(lvalley), .valley_locked_out(vlock),
    .overcurrent_fault_out(ocf), .undervoltage_fault_out(uvf),
    .latched_out(latched), .hiccup_out(hiccup));
  ffsup_conv_model model (.clk_sys_in(clk), .gate_in(gate),
    .short_en_in(short_en), .valley_out(valley), .short_out(short_lvl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The loop asks for a new on-time as soon as the switch is off.
  always @(posedge clk) begin
    on_cnt <= gate ? on_cnt + 1 : 0;
    req <= !(gate && on_cnt >= on_len);
  end

  function automatic logic [7:0] obs(input logic [2:0] s);
    case (s)
      3'h0: return {5'h00, latched, clamp_o, hiccup};
      3'h1: return peak;
      3'h2: return {6'h00, ocf, uvf};
      3'h3: return {4'h0, vlock, lvalley};
      3'h4: return {7'h00, gate};
      3'h5: return {7'h00, vlock};
      default: return meas;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [2:0] s, input logic [7:0] v);
    q.push_back({s, v});
  endtask

  // The short delay lets notes made at this fall be checked at this fall.
  always @(negedge clk) begin
    #1;
    while (q.size() > 0) begin
      nt = q.pop_front();
      check(obs(nt[10:8]), nt[7:0]);
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Counts drive edges of one direction; a stalled drive is a mismatch.
  task automatic edges(input int n, input logic rise, output int c);
    logic prev;
    c = 0;
    while (n > 0 && c < 3000) begin
      prev = gate;
      @(negedge clk);
      c++;
      if (prev !== gate && gate === rise) n--;
    end
    if (n > 0) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, n, 0);
    end
  endtask

  task automatic do_reset(input ffsup_variant_t v, input ffsup_clamp_t c);
    @(posedge clk);
    srst <= 1'b1;
    variant <= v;
    clamp <= c;
    flt <= 6'h00;
    short_en <= 1'b0;
    cc <= 1'b0;
    on_len <= 12 + $unsigned($random(seed)) % 16;
    cyc(16);
    note(0, 8'h00);
    note(1, 8'h00);
    @(posedge clk) srst <= 1'b0;
  endtask

  task automatic set_valley(input logic [2:0] v);
    @(posedge clk);
    vtgt <= v;
    line_chg <= 1'b1;
    @(posedge clk) line_chg <= 1'b0;
    edges(3, 1'b0, t);
  endtask

  // Raises one fault flag during an on-time, then expects a double hiccup.
  task automatic auto_rec(input int b, input int hold);
    edges(1, 1'b1, t);
    @(posedge clk) flt[b] <= 1'b1;
    cyc(hold);
    note(4, 8'h00);
    note(0, HIQ);
    @(posedge clk) flt[b] <= 1'b0;
    cyc(2 * HIC + 40);
    note(0, 8'h00);
    edges(2, 1'b1, t);
  endtask

  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("MISMATCH at %0t: seen %h expected %h", $time, 0, 1);
    stop_test();
  end

  initial begin
    srst = 1'b1;
    variant = FFSUP_VAR_A;
    clamp = FFSUP_CLAMP_NONE;
    req = 1'b0;
    line_chg = 1'b0;
    short_en = 1'b0;
    cc = 1'b0;
    flt = 6'h00;
    vtgt = 3'h1;
    do_reset(FFSUP_VAR_A, FFSUP_CLAMP_NONE);
    cyc(100);
    meas = {7'h00, peak < 8'h80};
    note(7, 8'h01);
    cyc(SS);
    note(1, 8'hFF);
    edges(1, 1'b1, t);
    edges(1, 1'b1, t);
    meas = {7'h00, t < CLAMP_HI_CYC};
    note(7, 8'h01);
    tgt = 3'(1 + $unsigned($random(seed)) % 4);
    set_valley(tgt);
    note(3, {5'h01, tgt});
    @(posedge clk) vtgt <= tgt % 3'h4 + 3'h1;
    edges(3, 1'b0, t);
    note(3, {5'h01, tgt});
    set_valley(3'h6);
    note(5, 8'h00);
    edges(2, 1'b1, t);
    for (int i = 1; i < 3; i++) begin
      do_reset(FFSUP_VAR_B, ffsup_clamp_t'(i));
      cyc(SS);
      edges(1, 1'b1, t);
      edges(1, 1'b1, t);
      lim = i == 1 ? CLAMP_LO_CYC : CLAMP_HI_CYC;
      meas = {6'h00, t >= lim, t <= lim + 20};
      note(7, 8'h03);
    end
    for (int i = 0; i < 3; i += 2) begin
      do_reset(ffsup_variant_t'(i), FFSUP_CLAMP_NONE);
      cyc(SS);
      edges(1, 1'b1, t);
      @(posedge clk) flt[1] <= 1'b1;
      cyc(6);
      note(4, 8'h00);
      cyc(CONFIRM_CYC + 20);
      note(0, LAT);
      @(posedge clk) flt[1] <= 1'b0;
      cyc(2 * HIC + 60);
      note(0, LAT);
    end
    do_reset(FFSUP_VAR_B, FFSUP_CLAMP_NONE);
    cyc(SS);
    auto_rec(1, 20);
    auto_rec(4, 40);
    do_reset(FFSUP_VAR_C, FFSUP_CLAMP_NONE);
    cyc(SS);
    auto_rec(5, CONFIRM_CYC + 3 * HIC);
    edges(1, 1'b0, t);
    @(posedge clk) short_en <= 1'b1;
    edges(3, 1'b0, t);
    cyc(4);
    note(0, 8'h00);
    edges(1, 1'b0, t);
    cyc(6);
    note(0, LAT);
    @(posedge clk) short_en <= 1'b0;
    cyc(400);
    note(4, 8'h00);
    for (int i = 0; i < 2; i++) begin
      do_reset(ffsup_variant_t'(i), FFSUP_CLAMP_NONE);
      cyc(SS);
      edges(1, 1'b0, t);
      @(posedge clk) flt[2] <= 1'b1;
      edges(3, 1'b0, t);
      cyc(4);
      note(0, 8'h00);
      edges(1, 1'b0, t);
      cyc(6);
      note(0, i == 0 ? LAT : HIQ);
    end
    for (int i = 0; i < 3; i += 2) begin
      do_reset(ffsup_variant_t'(i), FFSUP_CLAMP_NONE);
      @(posedge clk) flt[3] <= 1'b1;
      cc <= 1'b1;
      cyc(UVB - 40);
      note(0, 8'h00);
      cyc(i == 0 ? 100 : CONFIRM_CYC + 100);
      note(0, i == 0 ? HIQ : LAT);
    end
    do_reset(FFSUP_VAR_A, FFSUP_CLAMP_NONE);
    cyc(SS);
    @(posedge clk) flt[0] <= 1'b1;
    cyc(OCD - 60);
    @(posedge clk) flt[0] <= 1'b0;
    edges(6, 1'b0, t);
    @(posedge clk) flt[0] <= 1'b1;
    cyc(OCD - 60);
    note(0, 8'h00);
    t = 0;
    while (ocf !== 1'b1 && t < 200) begin
      cyc(1);
      t++;
    end
    meas = {7'h00, t > 40 && t < 160};
    note(7, 8'h01);
    cyc(1);
    note(0, HIQ);
    note(4, 8'h00);
    note(2, 8'h02);
    @(posedge clk) flt[0] <= 1'b0;
    cyc(2 * HIC + 40);
    meas = {7'h00, peak < 8'h80};
    note(7, 8'h01);
    note(0, 8'h00);
    edges(2, 1'b1, t);
    cyc(4);
    stop_test();
  end
endmodule // ffsup_top_bench
`default_nettype wire
